//--- core/acalsq_consts.vh
/*
  constants of the calibration sequencer: mode codes, timing counts, defaults.
  assumes one 10 MHz master clock and a modulator rate of master clock / 128.
*/
// Operation
// - mode 1,0,0 starts system-offset calibration
// - zero from system input, full from reference/gain
// - system-offset lasts six update periods
// - mode field clears to zero when done
// - ready inactive at start, valid after nine
// - following conversion samples system zero input
// - ready deasserts within one modulator cycle
// - unipolar endpoints, bipolar midscale to full
// - mode 1,0,1 enters background calibration
// - zero calibration after every update, rate/6
// - background never calibrates full scale
// - background refreshes offset coefficient automatically
// - background persists until mode rewritten
// - reset loads defaults and nominal coefficients
// - encodings for zero/full self and system
`ifndef ACALSQ_CONSTS_VH
`define ACALSQ_CONSTS_VH

// ----------------------------------------
// mode-select codes
// ----------------------------------------
`define ACS_MD_NORMAL 3'h0
`define ACS_MD_ZS_SYS 3'h2
`define ACS_MD_FS_SYS 3'h3
`define ACS_MD_SYS_OFF 3'h4
`define ACS_MD_BACKGND 3'h5
`define ACS_MD_ZS_SELF 3'h6
`define ACS_MD_FS_SELF 3'h7

// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define ACS_REG_MODE 4'h0
`define ACS_REG_STATUS 4'h1
`define ACS_REG_OFFSET 4'h2
`define ACS_REG_GAIN 4'h3
`define ACS_REG_CONFIG 4'h4
`define ACS_REG_RESULT 4'h5
`define ACS_CFG_BIPOLAR 0
`define ACS_CFG_SYNC 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define ACS_OFFSET_RST 24'h800000
`define ACS_GAIN_RST 24'h555555

// ----------------------------------------
// timing
// ----------------------------------------
`define ACS_MOD_DIV 128
`define ACS_PHASE_UPD 3
`define ACS_SYSOFF_UPD 6
`define ACS_TOTAL_UPD 9

`endif

//--- core/acalsq_divider.v
/*
  divider producing a one-cycle enable pulse every DIV clocks.
  assumes a synchronous active-high reset.
*/
`timescale 1ns/1ps
module acalsq_divider #(
  parameter DIV = 128,
  parameter W = 16
) (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // control
  input wire clr_i,
  // pulse
  output reg tick_o
);
  reg [W-1:0] cnt_q;
  always @(posedge mclk_i)
  begin
    if (rst_i || clr_i)
    begin
      cnt_q <= {W{1'b0}};
      tick_o <= 1'b0;
    end
    else if (cnt_q == DIV[W-1:0] - 1'b1)
    begin
      cnt_q <= {W{1'b0}};
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule // acalsq_divider

//--- core/acalsq_phase_cnt.v
/*
  counter of output-update periods within a calibration phase.
  assumes one-cycle update pulses and a synchronous reset.
*/
`timescale 1ns/1ps
module acalsq_phase_cnt #(
  parameter W = 4
) (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // control
  input wire clr_i,
  input wire upd_i,
  // count
  output reg [W-1:0] cnt_o
);
  always @(posedge mclk_i)
  begin
    if (rst_i || clr_i)
      cnt_o <= {W{1'b0}};
    else if (upd_i)
      cnt_o <= cnt_o + 1'b1;
  end
endmodule // acalsq_phase_cnt

//--- core/acalsq_top.v
/*
  calibration sequencer: mode field, calibration phases, result-valid flag,
  offset/gain coefficient registers and a plain register port.
  assumes conversion samples arrive as sample_i, one on each
  output update, and that update pulses come from an update divider.
*/
`timescale 1ns/1ps
`include "acalsq_consts.vh"
module acalsq_top #(
  parameter UPD_MODS = 24
) (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // register port
  input wire [3:0] addr_i,
  input wire [23:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [23:0] rdata_o,
  // converter datapath
  input wire [23:0] sample_i,
  // front end steering
  output reg sel_sys_input_o,
  output reg sel_ref_over_gain_o,
  output reg sel_int_zero_o,
  output reg coef_load_o,
  // status pins
  output reg result_valid_n_o,
  output reg mode_select_bit2_o,
  output reg mode_select_bit1_o,
  output reg mode_select_bit0_o
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_ZS = 3'h1;
  localparam ST_FS = 3'h2;
  localparam ST_CONV = 3'h3;
  localparam ST_BG_CONV = 3'h4;
  localparam ST_BG_ZS = 3'h5;

  reg [2:0] state_q;
  reg [2:0] mode_q;
  reg [2:0] src_q;
  reg [23:0] offset_q;
  reg [23:0] gain_q;
  reg [23:0] result_q;
  reg [1:0] cfg_q;
  reg pend_q;
  reg clr_cnt_q;
  wire mod_tick;
  wire upd_tick;
  wire [3:0] phase_cnt;
  wire [3:0] upd_div_cnt;
  wire wr_mode;
  wire phase_end;

  // ----------------------------------------
  // rate generation
  // ----------------------------------------
  acalsq_divider #(.DIV(`ACS_MOD_DIV), .W(8)) u_mod_div (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clr_i(cfg_q[`ACS_CFG_SYNC]),
    .tick_o(mod_tick)
  );

  acalsq_phase_cnt #(.W(4)) u_mods (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clr_i(upd_tick | cfg_q[`ACS_CFG_SYNC]),
    .upd_i(mod_tick),
    .cnt_o(upd_div_cnt)
  );

  assign upd_tick = mod_tick && (upd_div_cnt == UPD_MODS[3:0] - 4'h1);

  acalsq_phase_cnt #(.W(4)) u_phase (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clr_i(clr_cnt_q | wr_mode),
    .upd_i(upd_tick),
    .cnt_o(phase_cnt)
  );

  assign wr_mode = wr_i && (addr_i == `ACS_REG_MODE);
  assign phase_end = upd_tick && (phase_cnt == `ACS_PHASE_UPD - 1);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @(posedge mclk_i)
  begin
    clr_cnt_q <= 1'b0;
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      mode_q <= `ACS_MD_NORMAL;
      src_q <= 3'h0;
      offset_q <= `ACS_OFFSET_RST;
      gain_q <= `ACS_GAIN_RST;
      result_q <= 24'h000000;
      cfg_q <= 2'h0;
      pend_q <= 1'b0;
      result_valid_n_o <= 1'b1;
      coef_load_o <= 1'b0;
    end
    else
    begin
      coef_load_o <= 1'b0;
      if (wr_i && addr_i == `ACS_REG_CONFIG)
        cfg_q <= wdata_i[1:0];
      if (wr_i && addr_i == `ACS_REG_OFFSET)
        offset_q <= wdata_i;
      if (wr_i && addr_i == `ACS_REG_GAIN)
        gain_q <= wdata_i;
      if (rd_i && addr_i == `ACS_REG_RESULT)
        result_valid_n_o <= 1'b1;
      if (wr_mode)
      begin
        mode_q <= wdata_i[2:0];
        pend_q <= 1'b0;
        case (wdata_i[2:0])
          `ACS_MD_SYS_OFF, `ACS_MD_ZS_SYS, `ACS_MD_ZS_SELF:
          begin
            state_q <= ST_ZS;
            result_valid_n_o <= 1'b1;
          end
          `ACS_MD_FS_SYS, `ACS_MD_FS_SELF:
          begin
            state_q <= ST_FS;
            result_valid_n_o <= 1'b1;
          end
          `ACS_MD_BACKGND:
            state_q <= ST_BG_CONV;
          default:
            state_q <= ST_IDLE;
        endcase
      end
      else if (upd_tick)
      begin
        case (state_q)
          ST_IDLE:
          begin
            result_q <= sample_i - offset_q;
            result_valid_n_o <= 1'b0;
          end
          ST_ZS:
            if (phase_end)
            begin
              offset_q <= sample_i;
              coef_load_o <= 1'b1;
              clr_cnt_q <= 1'b1;
              if (mode_q == `ACS_MD_SYS_OFF)
                state_q <= ST_FS;
              else
              begin
                state_q <= ST_CONV;
                mode_q <= `ACS_MD_NORMAL;
              end
            end
          ST_FS:
            if (phase_end)
            begin
              gain_q <= cfg_q[`ACS_CFG_BIPOLAR] ? (sample_i - offset_q) : sample_i;
              coef_load_o <= 1'b1;
              clr_cnt_q <= 1'b1;
              state_q <= ST_CONV;
              src_q <= mode_q;
              mode_q <= `ACS_MD_NORMAL;
            end
          ST_CONV:
            if (phase_end)
            begin
              result_q <= sample_i - offset_q;
              result_valid_n_o <= 1'b0;
              state_q <= ST_IDLE;
            end
          ST_BG_CONV:
          begin
            result_q <= sample_i - offset_q;
            result_valid_n_o <= 1'b0;
            state_q <= ST_BG_ZS;
            clr_cnt_q <= 1'b1;
          end
          ST_BG_ZS:
            if (phase_cnt == `ACS_SYSOFF_UPD - 2)
            begin
              offset_q <= sample_i;
              coef_load_o <= 1'b1;
              state_q <= ST_BG_CONV;
            end
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // front end steering, status pins and register read-back
  // ----------------------------------------
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      sel_sys_input_o <= 1'b1;
      sel_ref_over_gain_o <= 1'b0;
      sel_int_zero_o <= 1'b0;
      mode_select_bit2_o <= 1'b0;
      mode_select_bit1_o <= 1'b0;
      mode_select_bit0_o <= 1'b0;
      rdata_o <= 24'h000000;
    end
    else
    begin
      sel_ref_over_gain_o <= (state_q == ST_FS) && (mode_q != `ACS_MD_FS_SYS);
      sel_int_zero_o <= (state_q == ST_BG_ZS) ||
        (state_q == ST_ZS && mode_q == `ACS_MD_ZS_SELF);
      sel_sys_input_o <= !((state_q == ST_FS && mode_q != `ACS_MD_FS_SYS) ||
        state_q == ST_BG_ZS || (state_q == ST_ZS && mode_q == `ACS_MD_ZS_SELF));
      mode_select_bit2_o <= mode_q[2];
      mode_select_bit1_o <= mode_q[1];
      mode_select_bit0_o <= mode_q[0];
      if (rd_i)
      begin
        case (addr_i)
          `ACS_REG_MODE: rdata_o <= {21'h0, mode_q};
          `ACS_REG_STATUS: rdata_o <= {16'h0, pend_q, src_q, state_q, result_valid_n_o};
          `ACS_REG_OFFSET: rdata_o <= offset_q;
          `ACS_REG_GAIN: rdata_o <= gain_q;
          `ACS_REG_CONFIG: rdata_o <= {22'h0, cfg_q};
          `ACS_REG_RESULT: rdata_o <= result_q;
          default: rdata_o <= 24'h000000;
        endcase
      end
      else
        rdata_o <= 24'h000000;
    end
  end
endmodule // acalsq_top

//--- verif/acalsq_props.sv
/* port checker of the calibration sequencer.
   bound to acalsq_top; counts cycles since the last mode write. */
`timescale 1ns/1ps
module acalsq_props #(
  parameter UPD_MODS = 24
) (
  input wire mclk_i,
  input wire rst_i,
  input wire [3:0] addr_i,
  input wire [23:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [23:0] rdata_o,
  input wire sel_sys_input_o,
  input wire sel_ref_over_gain_o,
  input wire sel_int_zero_o,
  input wire coef_load_o,
  input wire result_valid_n_o,
  input wire mode_select_bit2_o,
  input wire mode_select_bit1_o,
  input wire mode_select_bit0_o
);
  localparam int P = UPD_MODS * 128;
  wire [2:0] md = {mode_select_bit2_o, mode_select_bit1_o, mode_select_bit0_o};
  wire mw = wr_i && addr_i == 4'h0;
  reg [15:0] cnt_q;
  reg [2:0] cmd_q;
  always @(posedge mclk_i)
  begin
    if (rst_i || mw)
    begin
      cnt_q <= 16'h0000;
      cmd_q <= rst_i ? 3'h0 : wdata_i[2:0];
    end
    else if (cnt_q != 16'hffff)
      cnt_q <= cnt_q + 16'h0001;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_mode_load: assert property (mw |=> ##1 md == $past(wdata_i[2:0], 2))
    else $error("mode field did not take the written code");
  a_cal_start: assert property (mw && (wdata_i[1] || wdata_i[2:0] == 3'h4)
    |=> result_valid_n_o) else $error("ready not dropped at calibration start");
  a_sysoff_busy: assert property (cmd_q == 3'h4 && cnt_q >= 1 && cnt_q < 5 * P |-> md == 3'h4)
    else $error("system offset mode left early");
  a_sysoff_done: assert property (cmd_q == 3'h4 && cnt_q == 6 * P + 2 |-> md == 3'h0)
    else $error("mode field not cleared after six updates");
  a_valid_hold: assert property (cmd_q == 3'h4 && cnt_q < 8 * P |-> result_valid_n_o)
    else $error("ready came back too soon");
  a_zero_src: assert property (cmd_q == 3'h4 && cnt_q >= 1 && cnt_q < 2 * P
    |-> sel_sys_input_o && !sel_ref_over_gain_o) else $error("zero step not on system input");
  a_full_src: assert property (cmd_q == 3'h4 && cnt_q >= 4 * P && cnt_q < 5 * P
    |-> sel_ref_over_gain_o) else $error("full step not on reference");
  a_bg_stay: assert property (cmd_q == 3'h5 && cnt_q >= 1 |-> md == 3'h5 && !sel_ref_over_gain_o)
    else $error("background mode left or full scale used");
  a_norm_idle: assert property (cmd_q == 3'h0 && md == 3'h0
    |-> !sel_ref_over_gain_o && !sel_int_zero_o) else $error("calibration in normal mode");
  a_reset_dflt: assert property ($fell(rst_i) |-> result_valid_n_o && md == 3'h0)
    else $error("wrong state after reset");
  c_sysoff: cover property (md == 3'h4);
  c_bg: cover property (md == 3'h5);
  c_ready: cover property ($fell(result_valid_n_o));
endmodule // acalsq_props

bind acalsq_top acalsq_props #(.UPD_MODS(UPD_MODS)) u_props (.mclk_i(mclk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .sel_sys_input_o(sel_sys_input_o), .sel_ref_over_gain_o(sel_ref_over_gain_o),
  .sel_int_zero_o(sel_int_zero_o), .coef_load_o(coef_load_o),
  .result_valid_n_o(result_valid_n_o), .mode_select_bit2_o(mode_select_bit2_o),
  .mode_select_bit1_o(mode_select_bit1_o), .mode_select_bit0_o(mode_select_bit0_o));

//--- verif/acalsq_front.sv
/* front end model: sample seen by the selected input.
   assumes one clock; an unselected input toggles. */
`timescale 1ns/1ps
module acalsq_front #(
  parameter REF_LEVEL = 24'hc00000
) (
  input wire mclk_i,
  input wire [23:0] sys_level_i,
  input wire sel_sys_i,
  input wire sel_ref_i,
  input wire sel_zero_i,
  output reg [23:0] sample_o
);
  reg flip_q = 1'b0;
  always @(posedge mclk_i)
  begin
    flip_q <= ~flip_q;
    if (sel_ref_i)
      sample_o <= REF_LEVEL;
    else if (sel_zero_i)
      sample_o <= 24'h000000;
    else if (sel_sys_i)
      sample_o <= sys_level_i;
    else
      sample_o <= flip_q ? 24'haaaaaa : 24'h555555;
  end
endmodule // acalsq_front

//--- verif/acalsq_top_tb.sv
/* self-checking bench of the calibration sequencer.
   assumes short update period UPD_MODS = 2. */
`timescale 1ns/1ps
module acalsq_top_tb;
  localparam int P = 2 * 128;
  reg mclk_i = 1'b0;
  reg rst_i = 1'b1;
  reg [3:0] addr_i = 4'h0;
  reg [23:0] wdata_i = 24'h000000;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg rd_seen = 1'b0;
  reg [23:0] sys_level = 24'h000000;
  wire [23:0] rdata_o;
  wire [23:0] sample_i;
  wire sel_sys, sel_ref, sel_zero, coef_load, valid_n, md2, md1, md0;
  int fail_count = 0;
  int n_compared = 0;
  int n;
  int k;
  logic [23:0] exp_q[$];
  logic [2:0] codes[4] = '{3'h6, 3'h7, 3'h2, 3'h3};
  always #50 mclk_i = ~mclk_i;
  acalsq_top #(.UPD_MODS(2)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sample_i(sample_i),
    .sel_sys_input_o(sel_sys), .sel_ref_over_gain_o(sel_ref), .sel_int_zero_o(sel_zero),
    .coef_load_o(coef_load), .result_valid_n_o(valid_n), .mode_select_bit2_o(md2),
    .mode_select_bit1_o(md1), .mode_select_bit0_o(md0));
  acalsq_front u_front (.mclk_i(mclk_i), .sys_level_i(sys_level), .sel_sys_i(sel_sys),
    .sel_ref_i(sel_ref), .sel_zero_i(sel_zero), .sample_o(sample_i));
  task chk(input string what, input logic [23:0] seen, input logic [23:0] want);
    n_compared++;
    if (seen !== want)
    begin
      $display("BAD %s expected %h seen %h", what, want, seen);
      fail_count++;
    end
  endtask
  task finish_test;
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [23:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    if (!w)
      exp_q.push_back(d);
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask
  task wait_for(input bit on_valid, input int lim, output int c);
    for (c = 1; c <= lim; c++)
    begin
      @(negedge mclk_i);
      if (on_valid ? !valid_n : {md2, md1, md0} == 3'h0)
        break;
    end
    if (c > lim)
    begin
      fail_count++;
      finish_test;
    end
  endtask
  always @(posedge mclk_i)
  begin
    if (rd_seen)
      chk("rdata", rdata_o, exp_q.size() > 0 ? exp_q.pop_front() : 24'hxxxxxx);
    rd_seen <= rd_i;
  end
  initial
  begin
    k = $urandom(11);
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    bus(0, 4'h2, 24'h800000);
    bus(0, 4'h3, 24'h555555);
    bus(0, 4'h0, 24'h000000);
    bus(1, 4'he, 24'($urandom));
    bus(0, 4'he, 24'h000000);
    bus(1, 4'h4, 24'h000000);
    sys_level <= 24'($urandom);
    bus(1, 4'h0, 24'h000004);
    @(negedge mclk_i);
    wait_for(0, 7 * P, n);
    chk("sysoff len", 24'(n >= 5 * P && n <= 6 * P + 2), 24'h1);
    wait_for(1, 4 * P, n);
    chk("sysoff ready", 24'(n >= 2 * P && n <= 3 * P + 2), 24'h1);
    repeat (4) @(posedge mclk_i);
    bus(0, 4'h5, 24'h000000);
    foreach (codes[i])
    begin
      bus(1, 4'h0, 24'(codes[i]));
      repeat (2) @(negedge mclk_i);
      chk("ready off", 24'(valid_n), 24'h1);
      chk("mode", 24'({md2, md1, md0}), 24'(codes[i]));
      wait_for(0, 4 * P, n);
      chk("step len", 24'(n >= 2 * P && n <= 3 * P + 2), 24'h1);
      wait_for(1, 4 * P, n);
    end
    bus(1, 4'h0, 24'h000005);
    k = 0;
    repeat (20 * P)
    begin
      @(negedge mclk_i);
      k += coef_load;
    end
    chk("bg loads", 24'(k >= 3 && k <= 4), 24'h1);
    chk("bg mode", 24'({md2, md1, md0}), 24'h5);
    bus(1, 4'h0, 24'h000000);
    repeat (2) @(negedge mclk_i);
    chk("normal", 24'({md2, md1, md0}), 24'h0);
    finish_test;
  end
endmodule // acalsq_top_tb
